// [common/vpic_consts.vh]
// constants of the vectored priority interrupt controller
`ifndef VPIC_CONSTS_VH
`define VPIC_CONSTS_VH

// register byte offsets inside the 4 KiB window
`define VPIC_BASE_HI        20'hfffff
`define VPIC_OFS_SMR        12'h000
`define VPIC_OFS_SVR        12'h080
`define VPIC_OFS_NVEC       12'h100
`define VPIC_OFS_FVEC       12'h104
`define VPIC_OFS_CURNUM     12'h108
`define VPIC_OFS_PEND       12'h10c
`define VPIC_OFS_MASK       12'h110
`define VPIC_OFS_CORE       12'h114
`define VPIC_OFS_ENA        12'h120
`define VPIC_OFS_DIS        12'h124
`define VPIC_OFS_CLR        12'h128
`define VPIC_OFS_SET        12'h12c
`define VPIC_OFS_EOI        12'h130
`define VPIC_OFS_SPUR       12'h134
`define VPIC_OFS_FFEN       12'h140
`define VPIC_OFS_FFDIS      12'h144
`define VPIC_OFS_FFSTAT     12'h148

// source mode fields
`define VPIC_PRIO_LSB       0
`define VPIC_PRIO_MSB       2
`define VPIC_EDGE_BIT       5
`define VPIC_POL_BIT        6
`define VPIC_SMR_W          7

// sizes and reset values
`define VPIC_NSRC           32
`define VPIC_STACK_DEPTH    4'h8
`define VPIC_RST_WORD       32'h0000_0000
`define VPIC_RST_SMR        7'h00
`define VPIC_RST_NUM        5'h00
`define VPIC_RST_LVL        3'h0
`define VPIC_RST_CNT        4'h0
`define VPIC_ONE_CNT        4'h1
`define VPIC_HTRANS_NONSEQ  1
`define VPIC_HRESP_OKAY     1'b0

`endif

// [verilog/vpic_vec_mem.v]
// handler vector store, 32 words with registered read
`timescale 1ns/1ps
`default_nettype none
`include "vpic_consts.vh"

module vpic_vec_mem (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        wr_en,
  input  wire [4:0]  wr_idx,
  input  wire [31:0] wr_data,
  input  wire [4:0]  rd_idx,
  output reg  [31:0] rd_data_ff
);

  reg [31:0] mem [0:31];

  always @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data_ff <= `VPIC_RST_WORD;
    end else begin
      rd_data_ff <= mem[rd_idx];
    end
  end

endmodule // vpic_vec_mem

`default_nettype wire

// [verilog/vpic_stack.v]
// eight-entry stack of saved interrupt number and level
`timescale 1ns/1ps
`default_nettype none
`include "vpic_consts.vh"

module vpic_stack (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       push,
  input  wire       pop,
  input  wire [4:0] push_num,
  input  wire [2:0] push_lvl,
  output wire [4:0] top_num,
  output wire [2:0] top_lvl,
  output wire       empty
);

  reg [7:0] ent [0:7];
  reg [3:0] cnt_ff;
  wire [2:0] top_idx = cnt_ff[2:0] - 3'h1;

  assign empty   = (cnt_ff == `VPIC_RST_CNT);
  assign top_num = ent[top_idx][7:3];
  assign top_lvl = ent[top_idx][2:0];

  always @(posedge hclk) begin
    if (push && cnt_ff != `VPIC_STACK_DEPTH) begin
      ent[cnt_ff[2:0]] <= {push_num, push_lvl};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= `VPIC_RST_CNT;
    end else if (push && cnt_ff != `VPIC_STACK_DEPTH) begin
      cnt_ff <= cnt_ff + `VPIC_ONE_CNT;
    end else if (pop && !empty) begin
      cnt_ff <= cnt_ff - `VPIC_ONE_CNT;
    end
  end

endmodule // vpic_stack

`default_nettype wire

// [verilog/vpic_top.v]
// vectored priority interrupt controller with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "vpic_consts.vh"

// What this block does
// - enable and disable commands set and clear mask bits, mask readable
// - masked sources never take part in selection or request
// - set and clear commands force or clear edge latches
// - set and clear commands ignored for level sources
// - normal vector read clears edge latch of the chosen source only
// - no automatic clear for fast-forced sources
// - source 0 latch cleared by fast vector read
// - pending register shows live activity, masked or not
// - status register returns current interrupt number
// - core status register mirrors both request lines
// - eight-level controller drives normal line from sources 1 to 31, not forced
// - priority 7 highest to 0 lowest from source mode field
// - normal line asserts when enabled source meets its trigger condition
// - current interrupt chosen at vector read, which marks acceptance
// - equal priority ties go to lowest source number
// - current level equals current interrupt priority
// - in service, only strictly higher priority asserts the line
// - nesting pushes interrupted number and level, end-of-interrupt restores
// - stack holds eight entries
// - vector read returns stored vector of selected interrupt
// - normal vector register sits at absolute address 0xfffff100
// - normal vector read deasserts normal line
// - after pop, higher pending source reasserts line
module vpic_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  input  wire [31:0] irq_src,
  output reg         normal_req_n,
  output reg         fast_req_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [6:0]  smr_ff [0:31];
  reg  [31:0] irq_mask_reg_ff;
  reg  [31:0] edge_latch_ff;
  reg  [31:0] src_prev_ff;
  reg  [31:0] ffrc_ff;
  reg  [31:0] spur_ff;
  reg  [4:0]  cur_num_ff;
  reg  [2:0]  cur_lvl_ff;
  reg         in_svc_ff;
  reg  [31:0] rd_reg_ff;
  reg         rd_mem_ff;
  reg         wr_ff;
  reg  [11:0] waddr_ff;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [4:0] word_idx;
    input [11:0] ofs;
    begin
      word_idx = ofs[6:2];
    end
  endfunction

  function in_range;
    input [11:0] ofs;
    input [11:0] base;
    begin
      in_range = (ofs[11:7] == base[11:7]);
    end
  endfunction

  // ----------------------------------------------------------------
  // bus address phase
  // ----------------------------------------------------------------
  wire        hit   = hsel && hready && htrans[`VPIC_HTRANS_NONSEQ] &&
                      (haddr[31:12] == `VPIC_BASE_HI);
  wire        rd_go = hit && !hwrite;
  wire [11:0] aofs  = haddr[11:0];
  wire        nvec_rd = rd_go && (aofs == `VPIC_OFS_NVEC);
  wire        fvec_rd = rd_go && (aofs == `VPIC_OFS_FVEC);

  assign hreadyout = 1'b1;
  assign hresp     = `VPIC_HRESP_OKAY;

  wire        wr_cmd = wr_ff;
  wire [31:0] wbits  = hwdata;
  wire        w_ena   = wr_cmd && (waddr_ff == `VPIC_OFS_ENA);
  wire        w_dis   = wr_cmd && (waddr_ff == `VPIC_OFS_DIS);
  wire        w_clr   = wr_cmd && (waddr_ff == `VPIC_OFS_CLR);
  wire        w_set   = wr_cmd && (waddr_ff == `VPIC_OFS_SET);
  wire        w_eoi   = wr_cmd && (waddr_ff == `VPIC_OFS_EOI);
  wire        w_spur  = wr_cmd && (waddr_ff == `VPIC_OFS_SPUR);
  wire        w_ffen  = wr_cmd && (waddr_ff == `VPIC_OFS_FFEN);
  wire        w_ffdis = wr_cmd && (waddr_ff == `VPIC_OFS_FFDIS);
  wire        w_smr   = wr_cmd && in_range(waddr_ff, `VPIC_OFS_SMR);
  wire        w_svr   = wr_cmd && in_range(waddr_ff, `VPIC_OFS_SVR);

  // ----------------------------------------------------------------
  // source input stage
  // ----------------------------------------------------------------
  reg  [31:0] is_edge;
  reg  [31:0] act_lvl;
  reg  [31:0] pend;
  reg  [31:0] pol_bits;
  integer     i;
  integer     j;
  integer     m;
  integer     r;

  always @* begin
    for (i = 0; i < `VPIC_NSRC; i = i + 1) begin
      is_edge[i] = smr_ff[i][`VPIC_EDGE_BIT];
      act_lvl[i] = irq_src[i] ~^ smr_ff[i][`VPIC_POL_BIT];
      pol_bits[i] = smr_ff[i][`VPIC_POL_BIT];
    end
  end

  wire [31:0] pol_prev = ~(src_prev_ff ^ pol_bits);
  wire [31:0] edge_evt = is_edge & act_lvl & ~pol_prev;

  always @* begin
    pend = (is_edge & edge_latch_ff) | (~is_edge & act_lvl);
  end

  // ----------------------------------------------------------------
  // priority selection
  // ----------------------------------------------------------------
  wire [31:0] cand = pend & irq_mask_reg_ff & ~ffrc_ff & 32'hffff_fffe;
  reg  [4:0]  best_num;
  reg  [2:0]  best_lvl;
  reg         best_any;

  always @* begin
    best_num = `VPIC_RST_NUM;
    best_lvl = `VPIC_RST_LVL;
    best_any = 1'b0;
    // downward scan so ties land on the lowest number
    for (j = `VPIC_NSRC - 1; j > 0; j = j - 1) begin
      if (cand[j] && (!best_any ||
          smr_ff[j][`VPIC_PRIO_MSB:`VPIC_PRIO_LSB] >= best_lvl)) begin
        best_any = 1'b1;
        best_num = j[4:0];
        best_lvl = smr_ff[j][`VPIC_PRIO_MSB:`VPIC_PRIO_LSB];
      end
    end
  end

  // ----------------------------------------------------------------
  // nesting stack
  // ----------------------------------------------------------------
  wire       take   = nvec_rd && best_any;
  wire       push   = take && in_svc_ff;
  wire       pop    = w_eoi && in_svc_ff;
  wire [4:0] top_num;
  wire [2:0] top_lvl;
  wire       stk_empty;

  vpic_stack u_stack (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .push     (push),
    .pop      (pop),
    .push_num (cur_num_ff),
    .push_lvl (cur_lvl_ff),
    .top_num  (top_num),
    .top_lvl  (top_lvl),
    .empty    (stk_empty)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_num_ff <= `VPIC_RST_NUM;
      cur_lvl_ff <= `VPIC_RST_LVL;
      in_svc_ff  <= 1'b0;
    end else if (take) begin
      cur_num_ff <= best_num;
      cur_lvl_ff <= best_lvl;
      in_svc_ff  <= 1'b1;
    end else if (pop) begin
      if (stk_empty) begin
        in_svc_ff  <= 1'b0;
      end else begin
        cur_num_ff <= top_num;
        cur_lvl_ff <= top_lvl;
      end
    end
  end

  // ----------------------------------------------------------------
  // edge latches, mask, fast forcing
  // ----------------------------------------------------------------
  reg [31:0] auto_clr;

  always @* begin
    auto_clr = `VPIC_RST_WORD;
    if (take && !ffrc_ff[best_num]) begin
      auto_clr[best_num] = 1'b1;
    end
    if (fvec_rd) begin
      auto_clr[0] = 1'b1;
    end
  end

  wire [31:0] sw_clr = w_clr ? wbits : `VPIC_RST_WORD;
  wire [31:0] sw_set = w_set ? wbits : `VPIC_RST_WORD;
  wire [31:0] nxt_edge_latch = is_edge &
    ((edge_latch_ff & ~(sw_clr | auto_clr)) | sw_set | edge_evt);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_latch_ff   <= `VPIC_RST_WORD;
      src_prev_ff     <= `VPIC_RST_WORD;
      irq_mask_reg_ff <= `VPIC_RST_WORD;
      ffrc_ff         <= `VPIC_RST_WORD;
      spur_ff         <= `VPIC_RST_WORD;
    end else begin
      edge_latch_ff <= nxt_edge_latch;
      src_prev_ff   <= irq_src;
      if (w_ena || w_dis) begin
        irq_mask_reg_ff <= (irq_mask_reg_ff | (w_ena ? wbits : `VPIC_RST_WORD)) &
                           ~(w_dis ? wbits : `VPIC_RST_WORD);
      end
      if (w_ffen || w_ffdis) begin
        ffrc_ff <= ((ffrc_ff | (w_ffen ? wbits : `VPIC_RST_WORD)) &
                    ~(w_ffdis ? wbits : `VPIC_RST_WORD)) & 32'hffff_fffe;
      end
      if (w_spur) begin
        spur_ff <= wbits;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (r = 0; r < `VPIC_NSRC; r = r + 1) begin
        smr_ff[r] <= `VPIC_RST_SMR;
      end
    end else if (w_smr) begin
      smr_ff[word_idx(waddr_ff)] <= wbits[`VPIC_SMR_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // request lines
  // ----------------------------------------------------------------
  reg  [31:0] hi_cand;

  always @* begin
    for (m = 0; m < `VPIC_NSRC; m = m + 1) begin
      hi_cand[m] = cand[m] && (!in_svc_ff ||
        smr_ff[m][`VPIC_PRIO_MSB:`VPIC_PRIO_LSB] > cur_lvl_ff);
    end
  end

  wire nxt_irq = |hi_cand && !take;
  wire nxt_fiq = (pend[0] && irq_mask_reg_ff[0]) ||
                 |(pend & irq_mask_reg_ff & ffrc_ff);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      normal_req_n <= 1'b1;
      fast_req_n   <= 1'b1;
    end else begin
      normal_req_n <= ~nxt_irq;
      fast_req_n   <= ~nxt_fiq;
    end
  end

  // ----------------------------------------------------------------
  // vector memory and read path
  // ----------------------------------------------------------------
  reg  [4:0]  mem_ridx;
  wire [31:0] mem_rdata;

  always @* begin
    if (nvec_rd) begin
      mem_ridx = best_num;
    end else if (fvec_rd) begin
      mem_ridx = `VPIC_RST_NUM;
    end else begin
      mem_ridx = word_idx(aofs);
    end
  end

  vpic_vec_mem u_vec (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .wr_en      (w_svr),
    .wr_idx     (word_idx(waddr_ff)),
    .wr_data    (wbits),
    .rd_idx     (mem_ridx),
    .rd_data_ff (mem_rdata)
  );

  reg [31:0] nxt_rd_reg;
  reg        nxt_rd_mem;

  always @* begin
    nxt_rd_reg = `VPIC_RST_WORD;
    nxt_rd_mem = 1'b0;
    if (in_range(aofs, `VPIC_OFS_SMR)) begin
      nxt_rd_reg = {25'h0000000, smr_ff[word_idx(aofs)]};
    end else if (in_range(aofs, `VPIC_OFS_SVR) || aofs == `VPIC_OFS_FVEC) begin
      nxt_rd_mem = 1'b1;
    end else begin
      case (aofs)
        `VPIC_OFS_NVEC: begin
          nxt_rd_mem = best_any;
          nxt_rd_reg = spur_ff;                                       // no candidate
        end
        `VPIC_OFS_CURNUM: nxt_rd_reg = {27'h0000000, cur_num_ff};
        `VPIC_OFS_PEND:   nxt_rd_reg = pend;
        `VPIC_OFS_MASK:   nxt_rd_reg = irq_mask_reg_ff;
        `VPIC_OFS_CORE:   nxt_rd_reg = {30'h00000000, ~fast_req_n,
                                        ~normal_req_n};
        `VPIC_OFS_SPUR:   nxt_rd_reg = spur_ff;
        `VPIC_OFS_FFSTAT: nxt_rd_reg = ffrc_ff;
        default:          nxt_rd_reg = `VPIC_RST_WORD;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_reg_ff  <= `VPIC_RST_WORD;
      rd_mem_ff  <= 1'b0;
      wr_ff      <= 1'b0;
      waddr_ff   <= 12'h000;
    end else begin
      if (rd_go) begin
        rd_reg_ff  <= nxt_rd_reg;
        rd_mem_ff  <= nxt_rd_mem;
      end else if (rd_mem_ff) begin
        // freeze the memory word so hrdata stands until the next read
        rd_reg_ff  <= mem_rdata;
        rd_mem_ff  <= 1'b0;
      end
      wr_ff    <= hit && hwrite;
      waddr_ff <= aofs;
    end
  end

  assign hrdata = rd_mem_ff ? mem_rdata : rd_reg_ff;

endmodule // vpic_top

`default_nettype wire

// [tb/vpic_top_assertions.sv]
// concurrent checks on the controller bus and request ports
`timescale 1ns/1ps
`default_nettype none
module vpic_top_assertions (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [31:0] irq_src,
  input wire logic        normal_req_n,
  input wire logic        fast_req_n
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic        taken;
  logic        calm;
  logic        wr_dp_ff;
  logic [31:0] src_d_ff;
  logic [1:0]  calm_ff;
  assign taken = hsel && hready && htrans[1] && (haddr[31:12] == 20'hfffff);
  // sources and state quiet for three edges
  assign calm = (calm_ff == 2'b11) && (irq_src == src_d_ff) && !wr_dp_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_ff <= 1'b0;
      src_d_ff <= 32'h0;
      calm_ff  <= 2'b00;
    end else begin
      wr_dp_ff <= taken && hwrite;
      src_d_ff <= irq_src;
      calm_ff  <= {calm_ff[0], (irq_src == src_d_ff) && !wr_dp_ff};
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd(ofs);
    taken && !hwrite && (haddr[11:0] == ofs);
  endsequence
  sequence s_vec_busy;
    s_rd(12'h100) ##0 !normal_req_n;
  endsequence
  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready");
  property p_vec_drop;
    s_vec_busy |=> normal_req_n;
  endproperty
  a_vec_drop: assert property (p_vec_drop) else $error("line kept after vector read");
  property p_core_img;
    s_rd(12'h114) |=> (hrdata[1:0] == ~{$past(fast_req_n), $past(normal_req_n)});
  endproperty
  a_core_img: assert property (p_core_img) else $error("core status wrong");
  property p_rd_hold;
    !(taken && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped;
    s_rd(12'h1f0) |=> (hrdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset_idle;
    $rose(hresetn) |-> (normal_req_n && fast_req_n);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("line active at reset");
  property p_fast_keeps;
    s_rd(12'h104) ##0 (!normal_req_n && calm) |=> !normal_req_n;
  endproperty
  a_fast_keeps: assert property (p_fast_keeps) else $error("fast read hit normal");
  property p_spur_idle;
    s_rd(12'h100) ##0 (normal_req_n && calm) |=> normal_req_n;
  endproperty
  a_spur_idle: assert property (p_spur_idle) else $error("idle read raised line");
endmodule // vpic_top_assertions
bind vpic_top vpic_top_assertions u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .irq_src(irq_src), .normal_req_n(normal_req_n),
  .fast_req_n(fast_req_n)
);
`default_nettype wire

// [tb/vpic_core_model.sv]
// core side model taking the two request lines
`timescale 1ns/1ps
`default_nettype none
module vpic_core_model (
  input  wire logic hclk,
  input  wire logic normal_req_n,
  input  wire logic fast_req_n,
  output var logic  irq_on,
  output var logic  fiq_on
);
  // core sees a request one edge after the line falls
  always @(posedge hclk) begin
    irq_on <= ~normal_req_n;
    fiq_on <= ~fast_req_n;
  end
endmodule // vpic_core_model
`default_nettype wire

// [tb/vpic_top_tb.sv]
// self-checking bench of the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "vpic_consts.vh"
module vpic_top_tb;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        normal_req_n, fast_req_n, irq_on, fiq_on;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, irq_src, got;
  int          bad_count, compares;
  localparam logic [31:0] SPUR = 32'h0000_5a50;
  assign hready = hreadyout;
  vpic_top u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_src(irq_src),
    .normal_req_n(normal_req_n), .fast_req_n(fast_req_n)
  );
  vpic_core_model u_core (
    .hclk(hclk), .normal_req_n(normal_req_n), .fast_req_n(fast_req_n),
    .irq_on(irq_on), .fiq_on(fiq_on)
  );
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  function automatic logic [31:0] vec(input int n);
    return 32'h0001_0000 + 32'(n * 16);
  endfunction
  task automatic results;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus_edge;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      bad_count++;
      results();
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] o, input logic [31:0] wd);
    haddr  <= {`VPIC_BASE_HI, o};
    htrans <= 2'b10;
    hwrite <= w;
    bus_edge();
    htrans <= 2'b00;
    hwdata <= wd;
    bus_edge();
    got = hrdata;
  endtask
  task automatic wr(input logic [11:0] o, input logic [31:0] d);
    xfer(1'b1, o, d);
  endtask
  task automatic rd(input logic [11:0] o, input logic [31:0] exp);
    xfer(1'b0, o, 32'h0);
    chk(got, exp);
  endtask
  task automatic sm(input int n, input logic [6:0] v);
    wr(`VPIC_OFS_SMR + 12'(n * 4), {25'h0, v});
  endtask
  task automatic req(input logic fast);
    int n;
    n = 0;
    while ((fast ? fiq_on : irq_on) !== 1'b1 && n < 20) begin
      @(negedge hclk);
      n++;
    end
    chk({31'h0, fast ? fiq_on : irq_on}, 32'h1);
    if (n >= 20) results();
    @(posedge hclk);
  endtask
  task automatic lines(input logic [1:0] exp);
    repeat (4) @(negedge hclk);
    chk({30'h0, fast_req_n, normal_req_n}, {30'h0, exp});
    @(posedge hclk);
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    results();
  end
  initial begin
    hsel = 1'b1;
    hresetn = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    irq_src = 32'hffff_ffff;
    bad_count = 0;
    compares = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`VPIC_OFS_PEND, 32'h0);
    for (int i = 0; i < 32; i++) wr(`VPIC_OFS_SVR + 12'(i * 4), vec(i));
    wr(`VPIC_OFS_SPUR, SPUR);
    sm(0, 7'h20);
    sm(3, 7'h22);
    sm(4, 7'h05);
    sm(5, 7'h25);
    sm(9, 7'h07);
    for (int k = 0; k < 8; k++) sm(10 + k, 7'h20 | 7'(k));
    wr(`VPIC_OFS_ENA, 32'h8000_0001);
    rd(`VPIC_OFS_MASK, 32'h8000_0001);
    wr(`VPIC_OFS_DIS, 32'h8000_0000);
    rd(`VPIC_OFS_MASK, 32'h0000_0001);
    wr(`VPIC_OFS_DIS, 32'h0000_0001);
    irq_src[9] <= 1'b0;
    rd(`VPIC_OFS_MASK, 32'h0);
    rd(`VPIC_OFS_PEND, 32'h200);
    lines(2'b11);
    wr(`VPIC_OFS_SET, 32'h18);
    rd(`VPIC_OFS_PEND, 32'h208);
    wr(`VPIC_OFS_CLR, 32'h208);
    rd(`VPIC_OFS_PEND, 32'h200);
    $display("test mask and latch done");
    wr(`VPIC_OFS_ENA, 32'h38);
    wr(`VPIC_OFS_SET, 32'h08);
    req(1'b0);
    wr(`VPIC_OFS_SET, 32'h20);
    irq_src[4] <= 1'b0;
    rd(`VPIC_OFS_CORE, 32'h1);
    rd(`VPIC_OFS_NVEC, vec(4));
    rd(`VPIC_OFS_CURNUM, 32'h4);
    rd(`VPIC_OFS_PEND, 32'h238);
    lines(2'b11);
    irq_src[4] <= 1'b1;
    wr(`VPIC_OFS_EOI, 32'h0);
    req(1'b0);
    rd(`VPIC_OFS_NVEC, vec(5));
    rd(`VPIC_OFS_PEND, 32'h208);
    lines(2'b11);
    wr(`VPIC_OFS_EOI, 32'h0);
    req(1'b0);
    rd(`VPIC_OFS_NVEC, vec(3));
    wr(`VPIC_OFS_EOI, 32'h0);
    $display("test priority done");
    wr(`VPIC_OFS_ENA, 32'h0003_fc00);
    for (int k = 0; k < 8; k++) begin
      wr(`VPIC_OFS_SET, 32'h400 << k);
      req(1'b0);
      rd(`VPIC_OFS_NVEC, vec(10 + k));
    end
    for (int k = 7; k >= 0; k--) begin
      rd(`VPIC_OFS_CURNUM, 32'(10 + k));
      wr(`VPIC_OFS_EOI, 32'h0);
    end
    rd(`VPIC_OFS_NVEC, SPUR);
    rd(12'h1f0, 32'h0);
    $display("test nesting done");
    wr(`VPIC_OFS_ENA, 32'h1);
    wr(`VPIC_OFS_SET, 32'h8);
    irq_src[0] <= 1'b0;
    req(1'b1);
    req(1'b0);
    rd(`VPIC_OFS_FVEC, vec(0));
    rd(`VPIC_OFS_PEND, 32'h208);
    lines(2'b10);
    rd(`VPIC_OFS_NVEC, vec(3));
    wr(`VPIC_OFS_EOI, 32'h0);
    wr(`VPIC_OFS_FFEN, 32'h20);
    wr(`VPIC_OFS_SET, 32'h20);
    req(1'b1);
    lines(2'b01);
    rd(`VPIC_OFS_NVEC, SPUR);
    rd(`VPIC_OFS_PEND, 32'h220);
    $display("test fast done");
    results();
  end
endmodule // vpic_top_tb
`default_nettype wire
